// *** ssmsp_pkg.sv ***
// constants, types and state layout of the serial control port
package ssmsp_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          REG_COUNT       = 26;
    localparam logic [7:0]  REG_LAST        = 8'h19;
    localparam logic [7:0]  REG_SYNC_CTRL   = 8'h0e;
    localparam logic [7:0]  REG_SYNC_STATUS = 8'h14;
    localparam logic [7:0]  REG_MODE        = 8'h15;
    localparam logic [7:0]  MODE_RESET      = 8'hc0;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;

    // bit positions in the sync control and status registers
    localparam int CTRL_AVS_OVR = 1;
    localparam int CTRL_AVS_VAL = 0;
    localparam int STAT_LPOL    = 5;
    localparam int STAT_FACT    = 4;
    localparam int STAT_AVS     = 3;
    localparam int STAT_FPOL    = 2;
    localparam int STAT_GACT    = 1;
    localparam int STAT_HPOL    = 0;

    // ------------------------------------------------------------------
    // serial bus
    // ------------------------------------------------------------------
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h26;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    localparam logic [3:0] BIT_END       = 4'h9;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ        = 20000;
    localparam int ACT_TIMEOUT_MS = 50;
    localparam int ACT_CNT_W      = 20;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_REG   = 3'h3,
        ST_WDATA = 3'h2,
        ST_RDATA = 3'h6
    } ssmsp_state_e_t;

    // field order matches the mode register, msb first
    typedef struct packed {
        logic       port_split_enable;
        logic       parallel_timing;
        logic       first_pixel_port_swap;
        logic       packing_422;
        logic       input_channel;
        logic [1:0] bandwidth_code;
        logic       external_pixel_clock_select;
    } ssmsp_mode_t;

    typedef struct packed {
        logic line_sync_pol;
        logic frame_sync;
        logic frame_sync_pol;
        logic green_embedded_sync;
        logic hold_pol;
    } ssmsp_sync_t;

    typedef struct packed {
        ssmsp_state_e_t                st;
        logic [3:0]                    cnt;
        logic [7:0]                    shreg;
        logic [7:0]                    tx;
        logic [7:0]                    ptr;
        logic                          rw;
        logic                          nack;
        logic                          scl_d;
        logic                          sda_d;
        logic                          sda_o;
        logic                          sda_oe;
        logic [REG_COUNT-1:0][7:0]     regs;
        logic [7:0]                    status;
        logic                          frame_d;
        logic                          green_d;
        logic [ACT_CNT_W-1:0]          frame_cnt;
        logic [ACT_CNT_W-1:0]          green_cnt;
        logic                          frame_act;
        logic                          green_act;
        logic                          phase;
        logic                          load_a;
        logic                          load_b;
        ssmsp_mode_t                   mode;
        logic                          port_b_hiz;
        logic                          blue_hiz;
    } ssmsp_q_t;

endpackage

// *** ssmsp_top.sv ***
// two-wire slave control port with sync status and mode registers
//
// Function
// RQ1: status bit 5 gives detected line sync polarity, 1 positive.
// RQ2: status bit 4 is 1 while the selected frame sync toggles.
// RQ3: status bit 3 frame source: override copies control bit, else inverse activity.
// RQ4: status bit 2 gives frame sync polarity, 1 means active low.
// RQ5: status bit 1 is 1 while green-embedded sync shows activity.
// RQ6: status bit 0 gives detected hold input polarity, 1 positive.
// RQ7: mode bit 7 splits pixels over ports; 0 floats port B; resets 1.
// RQ8: mode bit 6 picks dual-port timing, resets 1, ignored single-port.
// RQ9: bit 6 high loads both ports every second pixel, else alternately.
// RQ10: mode bit 5 swaps which port gets the first pixel of a line.
// RQ11: mode bit 4 selects 4:2:2, floating the blue outputs.
// RQ12: mode bit 3 selects analog input channel 0 or 1.
// RQ13: mode bits 2:1 carry the analog bandwidth code.
// RQ14: mode bit 0 selects external pixel clock; resets 0.
// RQ15: data changes only with clock low; high-clock changes are start/stop.
// RQ16: start from idle begins a transfer; stop ends it.
// RQ17: first byte is address plus direction; acknowledge only on match.
// RQ18: slave address is 100110 plus the address select pin.
// RQ19: every byte moves most significant bit first.
// RQ20: without acknowledge the data line stays released.
// RQ21: write sets base address, auto-increments, saturates at 19h, rejects above.
// RQ22: reads start at the previously written base and increment.
// RQ23: repeated start without stop restarts addressing.
`timescale 1ns/10ps
`default_nettype none

module ssmsp_top
    import ssmsp_pkg::*;
#(
    parameter int unsigned ACT_TIMEOUT_CYC = ACT_TIMEOUT_MS * CLK_KHZ
) (
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output var  logic        sda_out,
    output var  logic        sda_oe_out,
    input  wire logic        address_select_pin_in,
    input  wire ssmsp_sync_t sync_in,
    input  wire logic        pixel_strobe_in,
    input  wire logic        line_start_in,
    output var  ssmsp_mode_t mode_out,
    output var  logic        port_b_hiz_out,
    output var  logic        blue_hiz_out,
    output var  logic        port_a_load_out,
    output var  logic        port_b_load_out
);

    localparam logic [ACT_CNT_W-1:0] ACT_LOAD = ACT_CNT_W'(ACT_TIMEOUT_CYC);

    ssmsp_q_t   q;
    ssmsp_q_t   next_q;
    logic       rise;
    logic       fall;
    logic       start_c;
    logic       stop_c;
    logic       addr_hit;
    logic [7:0] rd_byte;

    // ------------------------------------------------------------------
    // bus conditions
    // ------------------------------------------------------------------
    assign rise     = scl_in & ~q.scl_d;
    assign fall     = ~scl_in & q.scl_d;
    // sda moving while scl stays high is never data
    assign start_c  = scl_in & q.scl_d & q.sda_d & ~sda_in; // RQ15
    assign stop_c   = scl_in & q.scl_d & ~q.sda_d & sda_in; // RQ15
    assign addr_hit = q.shreg[7:1] ==
                      {SLAVE_ADDR_HI, address_select_pin_in}; // RQ18
    // status is assembled live, the rest comes from storage
    assign rd_byte  = (q.ptr == REG_SYNC_STATUS) ? q.status
                                                 : q.regs[q.ptr[4:0]];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_q        = q;
        next_q.scl_d  = scl_in;
        next_q.sda_d  = sda_in;
        next_q.load_a = 1'b0;
        next_q.load_b = 1'b0;

        if (start_c) begin
            // a repeated start lands here too, keeping the pointer
            next_q.st     = ST_ADDR; // RQ16 RQ23
            next_q.cnt    = 4'h0;
            next_q.sda_oe = 1'b0;
        end else if (stop_c) begin
            next_q.st     = ST_IDLE; // RQ16
            next_q.cnt    = 4'h0;
            next_q.sda_oe = 1'b0;
        end else if (q.st != ST_IDLE && rise) begin
            if (q.cnt < BIT_ACK) begin
                next_q.shreg = {q.shreg[6:0], sda_in}; // RQ19
            end
            if (q.cnt == BIT_ACK) begin
                next_q.nack = sda_in;
            end
            next_q.cnt = q.cnt + 4'h1;
        end else if (q.st != ST_IDLE && fall) begin
            if (q.cnt == BIT_ACK) begin
                unique case (q.st)
                    ST_ADDR: begin
                        if (addr_hit) begin
                            next_q.sda_oe = 1'b1; // RQ17
                            next_q.rw     = q.shreg[0];
                        end else begin
                            next_q.st = ST_IDLE; // RQ17 RQ20
                        end
                    end
                    ST_REG: begin
                        if (q.shreg <= REG_LAST) begin
                            next_q.sda_oe = 1'b1; // RQ21
                            next_q.ptr    = q.shreg;
                        end else begin
                            next_q.st = ST_IDLE; // RQ21 RQ20
                        end
                    end
                    ST_WDATA: begin
                        next_q.sda_oe = 1'b1;
                        // the status register silently drops writes
                        if (q.ptr != REG_SYNC_STATUS) begin
                            next_q.regs[q.ptr[4:0]] = q.shreg;
                        end
                        if (q.ptr != REG_LAST) begin
                            next_q.ptr = q.ptr + 8'h01; // RQ21
                        end
                    end
                    ST_RDATA: begin
                        next_q.sda_oe = 1'b0;
                        if (q.ptr != REG_LAST) begin
                            next_q.ptr = q.ptr + 8'h01; // RQ22
                        end
                    end
                    default: begin
                        next_q.st = ST_IDLE;
                    end
                endcase
            end else if (q.cnt == BIT_END) begin
                next_q.cnt    = 4'h0;
                next_q.sda_oe = 1'b0;
                unique case (q.st)
                    ST_ADDR: begin
                        if (q.rw) begin
                            next_q.st     = ST_RDATA; // RQ22
                            next_q.tx     = rd_byte;
                            next_q.sda_oe = ~rd_byte[7]; // RQ19
                        end else begin
                            next_q.st = ST_REG;
                        end
                    end
                    ST_REG: begin
                        next_q.st = ST_WDATA;
                    end
                    ST_WDATA: begin
                        next_q.st = ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (q.nack) begin
                            next_q.st = ST_IDLE; // RQ20
                        end else begin
                            next_q.tx     = rd_byte; // RQ22
                            next_q.sda_oe = ~rd_byte[7];
                        end
                    end
                    default: begin
                        next_q.st = ST_IDLE;
                    end
                endcase
            end else if (q.st == ST_RDATA && q.cnt != 4'h0) begin
                // drive only after scl has fallen
                next_q.tx     = {q.tx[6:0], 1'b0}; // RQ19
                next_q.sda_oe = ~q.tx[6]; // RQ15
            end
        end

        // --------------------------------------------------------------
        // activity detectors: a timeout, so a stuck line reads inactive
        // --------------------------------------------------------------
        next_q.frame_d = sync_in.frame_sync;
        next_q.green_d = sync_in.green_embedded_sync;
        if (sync_in.frame_sync != q.frame_d) begin
            next_q.frame_cnt = ACT_LOAD;
            next_q.frame_act = 1'b1; // RQ2
        end else if (q.frame_cnt != '0) begin
            next_q.frame_cnt = q.frame_cnt - 1'b1;
        end else begin
            next_q.frame_act = 1'b0; // RQ2
        end
        if (sync_in.green_embedded_sync != q.green_d) begin
            next_q.green_cnt = ACT_LOAD;
            next_q.green_act = 1'b1; // RQ5
        end else if (q.green_cnt != '0) begin
            next_q.green_cnt = q.green_cnt - 1'b1;
        end else begin
            next_q.green_act = 1'b0; // RQ5
        end

        // --------------------------------------------------------------
        // status assembly
        // --------------------------------------------------------------
        next_q.status            = STATUS_RESET;
        next_q.status[STAT_LPOL] = sync_in.line_sync_pol; // RQ1
        next_q.status[STAT_FACT] = q.frame_act; // RQ2
        next_q.status[STAT_AVS]  = q.regs[REG_SYNC_CTRL][CTRL_AVS_OVR]
                                 ? q.regs[REG_SYNC_CTRL][CTRL_AVS_VAL]
                                 : ~q.frame_act; // RQ3
        next_q.status[STAT_FPOL] = sync_in.frame_sync_pol; // RQ4
        next_q.status[STAT_GACT] = q.green_act; // RQ5
        next_q.status[STAT_HPOL] = sync_in.hold_pol; // RQ6

        // --------------------------------------------------------------
        // mode decode and pixel port steering
        // --------------------------------------------------------------
        next_q.mode       = ssmsp_mode_t'(q.regs[REG_MODE]); // RQ12 RQ13 RQ14
        next_q.port_b_hiz = ~q.mode.port_split_enable; // RQ7
        next_q.blue_hiz   = q.mode.packing_422; // RQ11
        if (line_start_in) begin
            next_q.phase = 1'b0; // RQ10
        end else if (pixel_strobe_in) begin
            next_q.phase = ~q.phase;
            if (!q.mode.port_split_enable) begin
                next_q.load_a = 1'b1; // RQ7 RQ8
            end else if (q.mode.parallel_timing) begin
                next_q.load_a = q.phase; // RQ9
                next_q.load_b = q.phase; // RQ9
            end else begin
                next_q.load_a = q.phase == q.mode.first_pixel_port_swap; // RQ10
                next_q.load_b = q.phase != q.mode.first_pixel_port_swap; // RQ9
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q                <= '0;
            q.regs[REG_MODE] <= MODE_RESET; // RQ7 RQ8 RQ14
            q.mode           <= ssmsp_mode_t'(MODE_RESET);
            q.scl_d          <= 1'b1;
            q.sda_d          <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign sda_out         = q.sda_o;
    assign sda_oe_out      = q.sda_oe;
    assign mode_out        = q.mode;
    assign port_b_hiz_out  = q.port_b_hiz;
    assign blue_hiz_out    = q.blue_hiz;
    assign port_a_load_out = q.load_a;
    assign port_b_load_out = q.load_b;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_ack_slot(ssmsp_state_e_t s);
        q.st == s && fall && !start_c && !stop_c && q.cnt == BIT_ACK;
    endsequence

    a_start_to_addr: assert property (start_c |=> q.st == ST_ADDR && q.cnt == 4'h0) else $error("start not taken"); // RQ16
    a_stop_to_idle: assert property (stop_c |=> q.st == ST_IDLE && !sda_oe_out) else $error("stop not taken"); // RQ16
    a_drive_scl_low: assert property ($rose(sda_oe_out) |-> !q.scl_d) else $error("sda driven while scl high"); // RQ15
    a_addr_ack: assert property (s_ack_slot(ST_ADDR) ##0 addr_hit |=> sda_oe_out [*1] ##0 q.st == ST_ADDR) else $error("address not acked"); // RQ17
    a_addr_nack: assert property (s_ack_slot(ST_ADDR) ##0 !addr_hit |=> !sda_oe_out && q.st == ST_IDLE) else $error("wrong address acked"); // RQ18
    a_reg_range: assert property (s_ack_slot(ST_REG) ##0 q.shreg > REG_LAST |=> !sda_oe_out) else $error("bad base acked"); // RQ21
    a_ptr_hold: assert property (s_ack_slot(ST_WDATA) ##0 q.ptr == REG_LAST |=> q.ptr == REG_LAST) else $error("pointer passed top"); // RQ21
    a_mode_write: assert property (s_ack_slot(ST_WDATA) ##0 q.ptr == REG_MODE |-> ##2 mode_out == ssmsp_mode_t'($past(q.shreg, 2))) else $error("mode write lost"); // RQ7
    a_avs_ovr: assert property (q.regs[REG_SYNC_CTRL][CTRL_AVS_OVR] |=> q.status[STAT_AVS] == $past(q.regs[REG_SYNC_CTRL][CTRL_AVS_VAL])) else $error("source override ignored"); // RQ3
    a_rd_release: assert property (q.st == ST_RDATA && q.cnt == BIT_END |-> !sda_oe_out) else $error("master ack slot driven"); // RQ20
    a_single_port: assert property (!line_start_in && pixel_strobe_in && !q.mode.port_split_enable |=> port_a_load_out && !port_b_load_out) else $error("single port steering"); // RQ7
    a_blue_float: assert property (q.mode.packing_422 |=> blue_hiz_out) else $error("blue not floated"); // RQ11

endmodule

`default_nettype wire

// *** ssmsp_bus_master.sv ***
// behavioural two-wire bus master driving the control port
`timescale 1ns/10ps
`default_nettype none

module ssmsp_bus_master (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output var  logic scl_out,
    output var  logic pull_out
);
    // ------------------------------------------------------------------
    // idle: both lines released high
    // ------------------------------------------------------------------
    initial begin
        scl_out  = 1'b1;
        pull_out = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // data moves only while the clock is low, sampled in the high phase
    task automatic bit_x(input logic b, output logic r);
        wait_clk(1);
        pull_out <= ~b;
        wait_clk(3);
        scl_out <= 1'b1;
        wait_clk(3);
        r = sda_in;
        wait_clk(1);
        scl_out <= 1'b0;
    endtask

    // also serves as a repeated start when entered with the clock low
    task automatic start_x();
        wait_clk(1);
        pull_out <= 1'b0;
        wait_clk(2);
        scl_out <= 1'b1;
        wait_clk(4);
        pull_out <= 1'b1;
        wait_clk(4);
        scl_out <= 1'b0;
    endtask

    task automatic stop_x();
        wait_clk(1);
        pull_out <= 1'b1;
        wait_clk(2);
        scl_out <= 1'b1;
        wait_clk(4);
        pull_out <= 1'b0;
        wait_clk(4);
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic byte_x(input logic [7:0] d, input logic a,
                          output logic [7:0] r, output logic ra);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(a, ra);
    endtask
endmodule

`default_nettype wire

// *** sync_status_mode_serial_port_tb_top.sv ***
// self-checking bench for the serial control port with a register model
`timescale 1ns/10ps
`default_nettype none

module sync_status_mode_serial_port_tb_top;
    import ssmsp_pkg::*;
    logic        core_clk_in = 1'b0;
    logic        rstn_in     = 1'b0;
    logic        pin         = 1'b0;
    logic        strobe      = 1'b0;
    logic        line_start  = 1'b0;
    ssmsp_sync_t sync        = '0;
    wire logic   scl;
    wire logic   pull;
    wire logic   sda_w;
    logic        sda_out;
    logic        sda_oe_out;
    ssmsp_mode_t mode_out;
    logic        port_b_hiz_out;
    logic        blue_hiz_out;
    logic        port_a_load_out;
    logic        port_b_load_out;
    logic        tog_f = 1'b0;
    logic        tog_g = 1'b0;
    logic [1:0]  tcnt  = 2'h0;
    logic [7:0]  wq[$];
    int          regs[REG_COUNT];
    int          ptr;
    int          n_fail;
    int          comparisons;

    // pull-up: the line is low only while someone drives it
    assign sda_w = !(pull || (sda_oe_out && !sda_out));

    ssmsp_top #(.ACT_TIMEOUT_CYC(16)) u_ssmsp_top (
        .core_clk_in           (core_clk_in),
        .rstn_in               (rstn_in),
        .scl_in                (scl),
        .sda_in                (sda_w),
        .sda_out               (sda_out),
        .sda_oe_out            (sda_oe_out),
        .address_select_pin_in (pin),
        .sync_in               (sync),
        .pixel_strobe_in       (strobe),
        .line_start_in         (line_start),
        .mode_out              (mode_out),
        .port_b_hiz_out        (port_b_hiz_out),
        .blue_hiz_out          (blue_hiz_out),
        .port_a_load_out       (port_a_load_out),
        .port_b_load_out       (port_b_load_out)
    );

    ssmsp_bus_master u_ssmsp_bus_master (
        .clk_in   (core_clk_in),
        .sda_in   (sda_w),
        .scl_out  (scl),
        .pull_out (pull)
    );

    always #25 core_clk_in = ~core_clk_in;

    // sync edges every four cycles keep activity inside the short window
    always @(posedge core_clk_in) begin
        tcnt <= tcnt + 2'h1;
        if (tcnt == 2'h0 && tog_f) begin
            sync.frame_sync <= ~sync.frame_sync;
        end
        if (tcnt == 2'h0 && tog_g) begin
            sync.green_embedded_sync <= ~sync.green_embedded_sync;
        end
    end

    // ------------------------------------------------------------------
    // model and checks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] mread(input int a);
        logic src;
        src = regs[14][1] ? regs[14][0] : ~tog_f;
        if (a != 20) begin
            return regs[a][7:0];
        end
        return {2'b00, sync.line_sync_pol, tog_f, src,
                sync.frame_sync_pol, tog_g, sync.hold_pol};
    endfunction

    task automatic complete_run();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic send_addr(input logic rw, input logic hit,
                             output logic ack);
        logic [7:0] r;
        logic       ra;
        u_ssmsp_bus_master.byte_x({SLAVE_ADDR_HI, pin ^ ~hit, rw}, 1'b1,
                                  r, ra);
        ack = ~ra;
    endtask

    task automatic reg_write(input int base);
        logic [7:0] r;
        logic       ra;
        logic       ack;
        u_ssmsp_bus_master.start_x();
        send_addr(1'b0, 1'b1, ack);
        check("addr ack", 8'h01, {7'h0, ack});
        u_ssmsp_bus_master.byte_x(base[7:0], 1'b1, r, ra);
        check("base ack", {7'h0, base <= 25}, {7'h0, ~ra});
        if (base <= 25) begin
            ptr = base;
            foreach (wq[i]) begin
                u_ssmsp_bus_master.byte_x(wq[i], 1'b1, r, ra);
                check("data ack", 8'h00, {7'h0, ra});
                if (ptr != 20) begin
                    regs[ptr] = wq[i];
                end
                if (ptr < 25) begin
                    ptr++;
                end
            end
        end
        u_ssmsp_bus_master.stop_x();
    endtask

    task automatic reg_read(input int base, input int n);
        logic [7:0] r;
        logic       ra;
        logic       ack;
        u_ssmsp_bus_master.start_x();
        send_addr(1'b0, 1'b1, ack);
        u_ssmsp_bus_master.byte_x(base[7:0], 1'b1, r, ra);
        ptr = base;
        u_ssmsp_bus_master.start_x();
        send_addr(1'b1, 1'b1, ack);
        check("read addr ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < n; i++) begin
            u_ssmsp_bus_master.byte_x(8'hff, i == n - 1, r, ra);
            check("read data", mread(ptr), r);
            if (ptr < 25) begin
                ptr++;
            end
        end
        u_ssmsp_bus_master.stop_x();
        check("line released", 8'h00, {7'h0, sda_oe_out});
    endtask

    task automatic pixel_run(input logic [7:0] v);
        logic ea;
        logic eb;
        @(posedge core_clk_in) line_start <= 1'b1;
        @(posedge core_clk_in) line_start <= 1'b0;
        for (int k = 1; k <= 6; k++) begin
            @(posedge core_clk_in) strobe <= 1'b1;
            @(posedge core_clk_in) strobe <= 1'b0;
            #1;
            ea = !v[7] || (v[6] ? k % 2 == 0 : (k % 2 == 1) ^ v[5]);
            eb = v[7] && (v[6] ? k % 2 == 0 : (k % 2 == 0) ^ v[5]);
            check("load a", {7'h0, ea}, {7'h0, port_a_load_out});
            check("load b", {7'h0, eb}, {7'h0, port_b_load_out});
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        logic [7:0]  v;
        logic [31:0] rnd;
        logic        ack;
        void'($urandom(32'h72161d20));
        foreach (regs[i]) begin
            regs[i] = 0;
        end
        regs[21] = 8'hc0;
        repeat (6) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        @(posedge core_clk_in);
        check("mode reset", 8'hc0, mode_out);
        reg_read(21, 1);
        pin <= 1'b1;
        u_ssmsp_bus_master.start_x();
        send_addr(1'b0, 1'b0, ack);
        check("foreign addr", 8'h00, {7'h0, ack});
        u_ssmsp_bus_master.stop_x();
        wq = {8'h55};
        reg_write(26);
        wq = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
        reg_write(23);
        reg_read(23, 4);
        for (int k = 0; k < 8; k++) begin
            rnd = $urandom;
            tog_f = k[0];
            tog_g = k[1];
            sync.line_sync_pol  <= rnd[0];
            sync.frame_sync_pol <= rnd[1];
            sync.hold_pol       <= rnd[2];
            // one byte only: the inner braces pack the control bits
            wq = {{6'h00, k[2], rnd[3]}};
            reg_write(14);
            wq = {rnd[15:8]};
            reg_write(20);
            reg_read(20, 2);
        end
        for (int k = 0; k < 8; k++) begin
            v = $urandom;
            v[7:5] = k[2:0];
            v[2:1] = k[1:0];
            wq = {v};
            reg_write(21);
            repeat (3) @(posedge core_clk_in);
            #1;
            check("mode out", v, mode_out);
            check("port b float", {7'h0, ~v[7]}, {7'h0, port_b_hiz_out});
            check("blue float", {7'h0, v[4]}, {7'h0, blue_hiz_out});
            pixel_run(v);
        end
        reg_read(21, 1);
        complete_run();
    end

    // sequence above needs roughly eleven thousand cycles
    initial begin
        repeat (80000) @(posedge core_clk_in);
        n_fail++;
        complete_run();
    end
endmodule

`default_nettype wire
